// *** dv/tb.sv ***
// Self-checking bench for the skip, branch, increment and OR unit.
// Assumes the unit alone; inputs change 1 ns after each rising mclk edge.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import skip_branch_pkg::*;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  logic [INSTR_W-1:0] instrWord = 14'h0000;
  logic instrValid = 1'b0;
  logic [PAGE_W-1:0] programPageLatch = 7'h00;
  logic [1:0] pointerMsb = 2'h0;
  logic instrReady;
  logic nopCycle;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] accumulator;
  logic zeroFlag;
  logic [PC_W-1:0] expPc = 15'h0000;
  int n_fail = 0;
  int check_count = 0;

  skip_branch_or_increment_ops i_skip_branch_or_increment_ops (
    .mclk(mclk),
    .rstn(rstn),
    .clkEn(clkEn),
    .instrWord(instrWord),
    .instrValid(instrValid),
    .programPageLatch(programPageLatch),
    .pointerMsb(pointerMsb),
    .instrReady(instrReady),
    .nopCycle(nopCycle),
    .pc(pc),
    .accumulator(accumulator),
    .zeroFlag(zeroFlag)
  );

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic regs(input logic [7:0] acc, input logic z);
    chk(16'(accumulator), 16'(acc));
    chk(16'(zeroFlag), 16'(z));
  endtask

  function automatic logic [13:0] fop(input logic [5:0] o, input logic d,
                                      input logic [6:0] f);
    return {o, d, f};
  endfunction

  function automatic logic [13:0] lit(input logic [7:0] k);
    return {6'h38, k};
  endfunction

  // Offers one word, then counts cycles and dead cycles until ready again.
  // A stuck sequencer would hang the run, so the wait gives up after 8.
  task automatic issue(input logic [13:0] w, input int cyc, input int nops,
                       input int step);
    int n;
    int k;
    n = 1;
    k = 0;
    instrWord = w;
    instrValid = 1'b1;
    @(posedge mclk);
    #1;
    instrValid = 1'b0;
    expPc = expPc + PC_W'(step);
    while (instrReady !== 1'b1) begin
      if (nopCycle === 1'b1) k++;
      if (n == 8) begin
        n_fail++;
        break;
      end
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n), 16'(cyc));
    chk(16'(k), 16'(nops));
    chk(16'(pc), 16'(expPc));
  endtask

  task automatic t_reset();
    chk(16'(pc), 16'h0000);
    regs(8'h00, 1'b0);
    chk(16'(instrReady), 16'h0001);
  endtask

  task automatic t_or_literal();
    issue(lit(8'h00), 1, 0, 1);
    regs(8'h00, 1'b1);
    issue(lit(8'hf0), 1, 0, 1);
    regs(8'hf0, 1'b0);
    issue(lit(8'h0f), 1, 0, 1);
    regs(8'hff, 1'b0);
  endtask

  // The file location starts unknown, so it is first filled by OR with ff.
  task automatic t_skip_increment();
    issue(fop(6'h04, 1'b1, 7'h10), 2, 0, 1);
    regs(8'hff, 1'b0);
    issue(fop(6'h0f, 1'b1, 7'h10), 3, 1, 2);
    regs(8'hff, 1'b0);
    issue(fop(6'h0a, 1'b0, 7'h10), 2, 0, 1);
    regs(8'h01, 1'b0);
  endtask

  task automatic t_skip_decrement();
    issue(fop(6'h0b, 1'b1, 7'h10), 2, 0, 1);
    regs(8'h01, 1'b0);
    issue(fop(6'h0a, 1'b1, 7'h10), 2, 0, 1);
    regs(8'h01, 1'b1);
    issue(fop(6'h0f, 1'b1, 7'h10), 2, 0, 1);
    regs(8'h01, 1'b1);
    issue(fop(6'h0b, 1'b0, 7'h10), 3, 1, 2);
    regs(8'h00, 1'b1);
    issue(fop(6'h04, 1'b0, 7'h10), 2, 0, 1);
    regs(8'h01, 1'b0);
  endtask

  task automatic t_branch();
    programPageLatch = 7'h55;
    expPc = 15'h55a5;
    issue({OPC_BRANCH, 11'h5a5}, 2, 1, 0);
    regs(8'h01, 1'b0);
    programPageLatch = 7'h2a;
    expPc = 15'h2fff;
    issue({OPC_BRANCH, 11'h7ff}, 2, 1, 0);
  endtask

  task automatic t_indirect();
    issue(lit(8'hff), 1, 0, 1);
    pointerMsb = 2'b10;
    issue(fop(6'h04, 1'b1, 7'h00), 2, 0, 1);
    issue(fop(6'h04, 1'b1, 7'h01), 3, 0, 1);
    pointerMsb = 2'b01;
    issue(fop(6'h04, 1'b1, 7'h00), 3, 0, 1);
    issue(fop(6'h0f, 1'b1, 7'h00), 4, 1, 2);
    pointerMsb = 2'b00;
  endtask

  task automatic t_boundary();
    issue(fop(6'h04, 1'b1, 7'h7f), 2, 0, 1);
    issue(fop(6'h0a, 1'b0, 7'h7f), 2, 0, 1);
    regs(8'h00, 1'b1);
  endtask

  // A word offered while the enable is low must never be taken.
  task automatic t_clock_enable();
    clkEn = 1'b0;
    instrWord = lit(8'h81);
    instrValid = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    instrValid = 1'b0;
    clkEn = 1'b1;
    chk(16'(pc), 16'(expPc));
    regs(8'h00, 1'b1);
  endtask

  // Reset lands in the middle of a file operation, then work resumes.
  task automatic t_mid_reset();
    @(posedge mclk);
    #1;
    instrWord = fop(6'h0f, 1'b1, 7'h10);
    instrValid = 1'b1;
    @(posedge mclk);
    #1;
    instrValid = 1'b0;
    rstn = 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    rstn = 1'b1;
    expPc = 15'h0000;
    issue(lit(8'h3c), 1, 0, 1);
    regs(8'h3c, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    t_reset();
    rstn = 1'b1;
    t_or_literal();
    t_skip_increment();
    t_skip_decrement();
    t_branch();
    t_indirect();
    t_boundary();
    t_clock_enable();
    t_mid_reset();
    end_of_test();
  end
endmodule

// *** verilog/file_register_ram.sv ***
// Bank of file registers: one write port, one read port, registered read.
// Assumes the caller holds write and read addresses stable for one edge.
module file_register_ram
  import skip_branch_pkg::*;
(
  input wire logic mclk,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [skip_branch_pkg::FADDR_W-1:0] wrAddr,
  input wire logic [skip_branch_pkg::DATA_W-1:0] wrData,
  input wire logic [skip_branch_pkg::FADDR_W-1:0] rdAddr,
  output logic [skip_branch_pkg::DATA_W-1:0] rdData
);
  import skip_branch_pkg::*;

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // No reset on the array itself, so it maps onto plain RAM.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule

// *** verilog/skip_branch_or_increment_ops.sv ***
// Execution unit for skip-on-zero, increment, OR and unconditional branch.
// Assumes instrWord is the word at pc, offered with instrValid.
module skip_branch_or_increment_ops
  import skip_branch_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [skip_branch_pkg::INSTR_W-1:0] instrWord,
  input wire logic instrValid,
  input wire logic [skip_branch_pkg::PAGE_W-1:0] programPageLatch,
  input wire logic [1:0] pointerMsb,
  output logic instrReady,
  output logic nopCycle,
  output logic [skip_branch_pkg::PC_W-1:0] pc,
  output logic [skip_branch_pkg::DATA_W-1:0] accumulator,
  output logic zeroFlag
);
  import skip_branch_pkg::*;

  seq_state_t stateQ, stateD;
  logic [PC_W-1:0] pcQ, pcD;
  logic [DATA_W-1:0] accQ, accD;
  logic zeroQ, zeroD;
  logic [INSTR_W-1:0] irQ, irD;
  logic skipQ, skipD;
  logic indQ, indD;

  logic [5:0] newOpc;
  logic [5:0] heldOpc;
  logic isBranch;
  logic isOrLit;
  logic isFileOp;
  logic heldSkipOp;
  logic heldZeroOp;
  logic [FADDR_W-1:0] newFileAddr;
  logic [FADDR_W-1:0] heldFileAddr;
  logic heldDest;
  logic [PC_W-1:0] branchTarget;
  logic [DATA_W-1:0] orLitResult;
  logic [DATA_W-1:0] fileData;
  logic [DATA_W-1:0] result;
  logic resultZero;
  logic ramWrEn;
  logic accept;
  logic [1:0] indirectHit;

  assign newOpc = instrWord[OPC_HI:OPC_LO];
  assign heldOpc = irQ[OPC_HI:OPC_LO];
  assign newFileAddr = instrWord[FADDR_W-1:0];
  assign heldFileAddr = irQ[FADDR_W-1:0];
  assign heldDest = irQ[DEST_BIT];

  assign isBranch = instrWord[OPC_HI:BR_OPC_LO] == OPC_BRANCH;
  assign isOrLit = newOpc == OPC_OR_LIT;
  assign isFileOp = newOpc == OPC_DEC_SKIP || newOpc == OPC_INC_SKIP ||
                    newOpc == OPC_INC_FILE || newOpc == OPC_OR_FILE;
  assign heldSkipOp = heldOpc == OPC_DEC_SKIP || heldOpc == OPC_INC_SKIP;
  assign heldZeroOp = heldOpc == OPC_INC_FILE || heldOpc == OPC_OR_FILE;

  // One compare per indirect register, each gated by its own pointer bit.
  for (genvar i = 0; i < 2; i++) begin : g_indirect
    assign indirectHit[i] = pointerMsb[i] &&
        newFileAddr == (i == 0 ? INDIRECT0_ADDR : INDIRECT1_ADDR);
  end

  // The page latch supplies the four page bits above the literal.
  assign branchTarget = {programPageLatch[PAGE_HI:PAGE_LO],
                         instrWord[TARGET_HI:0]};
  assign orLitResult = accQ | instrWord[DATA_W-1:0];

  // Sums are kept at eight bits so both directions wrap.
  always_comb begin
    case (heldOpc)
      OPC_DEC_SKIP: result = fileData - DATA_ONE;
      OPC_INC_SKIP: result = fileData + DATA_ONE;
      OPC_INC_FILE: result = fileData + DATA_ONE;
      OPC_OR_FILE: result = accQ | fileData;
      default: result = fileData;
    endcase
  end
  assign resultZero = result == DATA_ZERO;

  assign accept = stateQ == ST_FETCH && instrValid;
  assign ramWrEn = stateQ == ST_EXEC && heldDest;

  file_register_ram u_files (
    .mclk(mclk),
    .clkEn(clkEn),
    .wrEn(ramWrEn),
    .wrAddr(heldFileAddr),
    .wrData(result),
    .rdAddr(newFileAddr),
    .rdData(fileData)
  );

  always_comb begin
    stateD = stateQ;
    pcD = pcQ;
    accD = accQ;
    zeroD = zeroQ;
    irD = irQ;
    skipD = skipQ;
    indD = indQ;
    case (stateQ)
      ST_FETCH: begin
        if (instrValid) begin
          pcD = pcQ + PC_STEP;
          if (isBranch) begin
            // The fetched successor is dropped: a dead cycle follows.
            pcD = branchTarget;
            stateD = ST_NOP;
          end else if (isOrLit) begin
            accD = orLitResult;
            zeroD = orLitResult == DATA_ZERO;
          end else if (isFileOp) begin
            irD = instrWord;
            skipD = 1'b0;
            indD = |indirectHit;
            stateD = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (!heldDest) begin
          accD = result;
        end
        if (heldZeroOp) begin
          zeroD = resultZero;
        end
        // A zero result of a decrement or increment skip passes over the next word in program memory.
        skipD = heldSkipOp && resultZero;
        if (heldSkipOp && resultZero) begin
          pcD = pcQ + PC_STEP;
        end
        if (indQ) begin
          stateD = ST_EXTRA;
        end else if (heldSkipOp && resultZero) begin
          stateD = ST_NOP;
        end else begin
          stateD = ST_FETCH;
        end
      end
      ST_EXTRA: begin
        stateD = skipQ ? ST_NOP : ST_FETCH;
      end
      ST_NOP: begin
        skipD = 1'b0;
        stateD = ST_FETCH;
      end
      default: begin
        stateD = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= ST_FETCH;
      pcQ <= PC_RESET;
      accQ <= ACC_RESET;
      zeroQ <= ZERO_RESET;
      irQ <= INSTR_RESET;
      skipQ <= 1'b0;
      indQ <= 1'b0;
    end else if (clkEn) begin
      stateQ <= stateD;
      pcQ <= pcD;
      accQ <= accD;
      zeroQ <= zeroD;
      irQ <= irD;
      skipQ <= skipD;
      indQ <= indD;
    end
  end

  assign instrReady = stateQ == ST_FETCH;
  assign nopCycle = stateQ == ST_NOP;
  assign pc = pcQ;
  assign accumulator = accQ;
  assign zeroFlag = zeroQ;

  // Checks count only enabled edges, since a low enable freezes everything.
  default clocking cb @(posedge mclk iff clkEn);
  endclocking
  default disable iff (!rstn);

  AST_BRANCH_TARGET: assert property (
    accept && isBranch |=> pcQ == $past(branchTarget))
    else $error("branch did not load the page and literal into pc");

  AST_BRANCH_TWO_CYCLES: assert property (
    accept && isBranch |=> nopCycle && !instrReady ##1 instrReady)
    else $error("branch did not take exactly two cycles");

  AST_BRANCH_FLAGS: assert property (
    accept && isBranch |=> zeroFlag == $past(zeroQ) &&
                           accumulator == $past(accQ))
    else $error("branch changed the accumulator or zero flag");

  AST_OR_LITERAL: assert property (
    accept && isOrLit |=> accumulator == $past(orLitResult) &&
                          zeroFlag == ($past(orLitResult) == DATA_ZERO) &&
                          instrReady)
    else $error("or literal result or zero flag wrong");

  AST_SKIP_TAKEN: assert property (
    stateQ == ST_EXEC && heldSkipOp && resultZero && !indQ
      |=> nopCycle ##1 instrReady)
    else $error("zero result did not insert one nop cycle");

  AST_SKIP_NOT_TAKEN: assert property (
    stateQ == ST_EXEC && heldSkipOp && !resultZero && !indQ |=> instrReady)
    else $error("nonzero result did not go on to the next word");

  AST_SKIP_PC: assert property (
    accept && isFileOp |=> ##1 pcQ == $past(pcQ, 2) + PC_STEP +
                           (skipQ ? PC_STEP : 15'h0000))
    else $error("skip did not pass over the next word");

  AST_INDIRECT_EXTRA: assert property (
    stateQ == ST_EXEC && indQ |=> stateQ == ST_EXTRA && !instrReady)
    else $error("indirect access did not add a cycle");

  AST_DEST_SELECT: assert property (
    stateQ == ST_EXEC && heldDest |=> accumulator == $past(accQ))
    else $error("file destination disturbed the accumulator");

  AST_DEST_ACC: assert property (
    stateQ == ST_EXEC && !heldDest |=> accumulator == $past(result))
    else $error("accumulator did not take the result");

  AST_SKIP_KEEPS_FLAGS: assert property (
    stateQ == ST_EXEC && heldSkipOp |=> zeroFlag == $past(zeroQ))
    else $error("skip instruction changed the zero flag");

  AST_ZERO_FLAG: assert property (
    stateQ == ST_EXEC && heldZeroOp |=> zeroFlag == $past(resultZero))
    else $error("zero flag does not match the result");

  AST_WRAP: assert property (
    stateQ == ST_EXEC && heldOpc != OPC_OR_FILE &&
    fileData == (heldOpc == OPC_DEC_SKIP ? DATA_ONE : 8'hff) |-> resultZero)
    else $error("increment or decrement did not wrap to zero");

  AST_INDIRECT_DECODE: assert property (
    accept && isFileOp &&
    ((newFileAddr == INDIRECT0_ADDR && pointerMsb[0]) ||
     (newFileAddr == INDIRECT1_ADDR && pointerMsb[1])) |=> ##1 stateQ == ST_EXTRA)
    else $error("indirect file access did not reach the extra cycle");

  AST_NOP_ONE_CYCLE: assert property (
    nopCycle |=> instrReady)
    else $error("inserted nop lasted more than one cycle");

  AST_INC_FILE_NO_SKIP: assert property (
    stateQ == ST_EXEC && heldOpc == OPC_INC_FILE && !indQ |=> instrReady)
    else $error("plain increment did not return straight to fetch");

  AST_HOLD_IN_WAIT: assert property (
    stateQ == ST_EXTRA || stateQ == ST_NOP
      |=> $stable(pcQ) && $stable(accQ) && $stable(zeroQ))
    else $error("state changed during an extra or nop cycle");

  AST_PC_STEP: assert property (
    accept && !isBranch |=> pcQ == $past(pcQ) + PC_STEP)
    else $error("taken word did not advance pc by one");

  AST_FETCH_IDLE: assert property (
    stateQ == ST_FETCH && !instrValid
      |=> $stable(pcQ) && $stable(accQ) && instrReady)
    else $error("idle fetch cycle changed pc or accumulator");

  AST_UNKNOWN_OPC: assert property (
    accept && !isBranch && !isOrLit && !isFileOp
      |=> instrReady && $stable(accQ) && $stable(zeroQ))
    else $error("undecoded word changed the accumulator or flag");

  // The enable-gated default clock cannot see a frozen edge, hence mclk.
  AST_FREEZE: assert property (
    @(posedge mclk) !clkEn |=> $stable(stateQ) && $stable(pcQ) &&
                               $stable(accQ) && $stable(zeroQ))
    else $error("state moved while the clock enable was low");

  COV_BRANCH: cover property (accept && isBranch ##2 instrReady);
  COV_SKIP: cover property (stateQ == ST_EXEC && heldSkipOp && resultZero);
  COV_INDIRECT_SKIP: cover property (
    stateQ == ST_EXTRA && skipQ ##1 nopCycle);
  COV_OR_FILE: cover property (stateQ == ST_EXEC && heldOpc == OPC_OR_FILE);

endmodule

// *** verilog/skip_branch_pkg.sv ***
// Shared constants for the skip, branch, increment and OR execution unit.
// Assumes a 14-bit instruction word and a 128-entry bank of 8-bit files.
package skip_branch_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PAGE_W = 7;

  // Field positions inside the instruction word and the page latch.
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int BR_OPC_LO = 11;
  localparam int DEST_BIT = 7;
  localparam int TARGET_HI = 10;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 3;

  // Six-bit opcode fields of the decoded instructions.
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC_FILE = 6'h0a;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  // Three-bit prefix of the unconditional branch.
  localparam logic [2:0] OPC_BRANCH = 3'h5;

  // File addresses of the two indirect access registers.
  localparam logic [FADDR_W-1:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [FADDR_W-1:0] INDIRECT1_ADDR = 7'h01;

  localparam int FILE_DEPTH = 128;

  // Values after reset.
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;

  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Gray-coded sequencer: fetch, execute, extra, nop, back to fetch.
  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_EXEC = 2'h1,
    ST_EXTRA = 2'h3,
    ST_NOP = 2'h2
  } seq_state_t;

endpackage
